//--- rtl/pss_consts.svh
// Constants for the preset speed selector: register map, field layout, codes.
// Assumes a 16-bit plain register port with an 8-bit word address.
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

`define PSS_NUM_STEPS 16
`define PSS_NUM_INPUTS 6
`define PSS_ADDR_W 8
`define PSS_DATA_W 16

// Word addresses
`define PSS_ADDR_STEP_LAST 8'h1F
`define PSS_ADDR_RAMP_LOW 8'h20
`define PSS_ADDR_RAMP_HIGH 8'h21
`define PSS_ADDR_ACTIVE_STEP 8'h22
`define PSS_ADDR_CONTROL 8'h23
`define PSS_ADDR_FUNC_FIRST 8'h24
`define PSS_ADDR_FUNC_LAST 8'h29

// Control register bits
`define PSS_CTRL_ENABLE_BIT 0
`define PSS_CTRL_MINUTES_BIT 1
`define PSS_CTRL_W 2

// Input function codes
`define PSS_FUNC_W 5
`define PSS_FUNC_SEL_BIT1 5'h10
`define PSS_FUNC_SEL_BIT2 5'h11
`define PSS_FUNC_SEL_BIT3 5'h12
`define PSS_FUNC_SEL_BIT4 5'h13
`define PSS_FUNC_PAUSE 5'h14

// Speed in tenths of a percent, signed
`define PSS_SPEED_MAX 16'sh03E8
`define PSS_SPEED_MIN (-16'sh03E8)

// Reset values
`define PSS_SPEED_RST 16'h0000
`define PSS_TIME_RST 16'h0000
`define PSS_RAMP_RST 16'h0000
`define PSS_STEP_RST 4'h0
`define PSS_CTRL_RST 2'h0
`define PSS_FUNC_RST 5'h00
`define PSS_ZERO16 16'h0000

`define PSS_STEPS_PER_RAMP_WORD 8
`define PSS_RAMP_FIELD_W 2

`endif

//--- rtl/pss_pkg.sv
// Types shared by the preset speed selector.
// Assumes pss_consts.svh is included beside it.
`include "pss_consts.svh"

package pss_pkg;
    typedef logic [`PSS_DATA_W-1:0] pss_word_t;
    typedef logic [3:0] pss_step_t;
    typedef logic [`PSS_FUNC_W-1:0] pss_func_t;
    typedef logic [1:0] pss_ramp_t;
endpackage

//--- rtl/pss_preset_speed_selector.sv
// Preset speed selector: sixteen stored speed steps picked by terminal inputs.
// Assumes terminals are asynchronous pins and software uses the plain register port.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "pss_consts.svh"

module pss_preset_speed_selector (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [`PSS_ADDR_W-1:0] reg_addr,
    input wire logic [`PSS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`PSS_DATA_W-1:0] reg_rdata,
    input wire logic [`PSS_NUM_INPUTS-1:0] term_in,
    output logic [`PSS_DATA_W-1:0] speed_cmd,
    output logic [`PSS_DATA_W-1:0] step_time,
    output logic time_in_minutes,
    output logic [1:0] ramp_group,
    output logic [3:0] active_step,
    output logic preset_active,
    output logic preset_paused
);

    // True when an input that carries the given function code is high
    function automatic logic pss_has_func(
        input pss_pkg::pss_func_t codes [`PSS_NUM_INPUTS],
        input logic [`PSS_NUM_INPUTS-1:0] level,
        input pss_pkg::pss_func_t code
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `PSS_NUM_INPUTS; i++) begin
            if (codes[i] == code && level[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Clamp a written speed into the legal tenth-percent range
    function automatic pss_pkg::pss_word_t pss_clamp_speed(input pss_pkg::pss_word_t raw);
        logic signed [`PSS_DATA_W-1:0] s;
        s = signed'(raw);
        if (s > `PSS_SPEED_MAX) begin
            return pss_pkg::pss_word_t'(`PSS_SPEED_MAX);
        end else if (s < `PSS_SPEED_MIN) begin
            return pss_pkg::pss_word_t'(`PSS_SPEED_MIN);
        end
        return raw;
    endfunction

    // Terminal synchronisers: three stages, accept a level once stages two and three agree
    logic [`PSS_NUM_INPUTS-1:0] sync1_ff;
    logic [`PSS_NUM_INPUTS-1:0] sync2_ff;
    logic [`PSS_NUM_INPUTS-1:0] sync3_ff;
    logic [`PSS_NUM_INPUTS-1:0] term_ff;
    logic [`PSS_NUM_INPUTS-1:0] nxt_term;

    genvar g;
    generate
        for (g = 0; g < `PSS_NUM_INPUTS; g++) begin : g_sync
            always_comb begin
                nxt_term[g] = term_ff[g];
                if (sync2_ff[g] == sync3_ff[g]) begin
                    nxt_term[g] = sync3_ff[g];
                end
            end
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_ff[g] <= 1'b0;
                    sync2_ff[g] <= 1'b0;
                    sync3_ff[g] <= 1'b0;
                    term_ff[g] <= 1'b0;
                end else begin
                    sync1_ff[g] <= term_in[g];
                    sync2_ff[g] <= sync1_ff[g];
                    sync3_ff[g] <= sync2_ff[g];
                    term_ff[g] <= nxt_term[g];
                end
            end
        end
    endgenerate

    // Parameter store
    pss_pkg::pss_word_t speed_ff [`PSS_NUM_STEPS];
    pss_pkg::pss_word_t time_ff [`PSS_NUM_STEPS];
    pss_pkg::pss_word_t nxt_speed [`PSS_NUM_STEPS];
    pss_pkg::pss_word_t nxt_time [`PSS_NUM_STEPS];
    pss_pkg::pss_word_t ramp_low_ff;
    pss_pkg::pss_word_t ramp_high_ff;
    pss_pkg::pss_word_t nxt_ramp_low;
    pss_pkg::pss_word_t nxt_ramp_high;
    logic [`PSS_CTRL_W-1:0] ctrl_ff;
    logic [`PSS_CTRL_W-1:0] nxt_ctrl;
    pss_pkg::pss_func_t func_ff [`PSS_NUM_INPUTS];
    pss_pkg::pss_func_t nxt_func [`PSS_NUM_INPUTS];
    pss_pkg::pss_word_t rdata_ff;
    pss_pkg::pss_word_t nxt_rdata;

    // Selection state
    pss_pkg::pss_step_t step_ff;
    pss_pkg::pss_step_t nxt_step;
    pss_pkg::pss_step_t sel_code;
    logic pause_req;
    logic enable;

    pss_pkg::pss_word_t speed_out_ff;
    pss_pkg::pss_word_t time_out_ff;
    pss_pkg::pss_ramp_t ramp_out_ff;
    logic minutes_out_ff;
    logic active_out_ff;
    logic paused_out_ff;
    pss_pkg::pss_word_t nxt_speed_out;
    pss_pkg::pss_word_t nxt_time_out;
    pss_pkg::pss_ramp_t nxt_ramp_out;
    logic nxt_minutes_out;
    logic nxt_active_out;
    logic nxt_paused_out;

    logic [2:0] ramp_slot;
    pss_pkg::pss_word_t ramp_word;
    logic [3:0] step_addr;
    logic [2:0] func_addr;

    assign step_addr = reg_addr[4:1];
    assign func_addr = 3'(reg_addr - `PSS_ADDR_FUNC_FIRST);

    // Address classes; one decoder serves the write and the read path alike
    typedef enum {
        PSS_RK_SPEED,
        PSS_RK_TIME,
        PSS_RK_RAMP_LOW,
        PSS_RK_RAMP_HIGH,
        PSS_RK_STATUS,
        PSS_RK_CONTROL,
        PSS_RK_FUNC,
        PSS_RK_NONE
    } pss_rkind_t;

    // Unmapped words fall to the none class, so they read zero and ignore writes
    function automatic pss_rkind_t pss_decode(input logic [`PSS_ADDR_W-1:0] addr);
        pss_rkind_t kind;
        kind = PSS_RK_NONE;
        if (addr <= `PSS_ADDR_STEP_LAST) begin
            kind = addr[0] ? PSS_RK_TIME : PSS_RK_SPEED;
        end else if (addr == `PSS_ADDR_RAMP_LOW) begin
            kind = PSS_RK_RAMP_LOW;
        end else if (addr == `PSS_ADDR_RAMP_HIGH) begin
            kind = PSS_RK_RAMP_HIGH;
        end else if (addr == `PSS_ADDR_ACTIVE_STEP) begin
            kind = PSS_RK_STATUS;
        end else if (addr == `PSS_ADDR_CONTROL) begin
            kind = PSS_RK_CONTROL;
        end else if (addr >= `PSS_ADDR_FUNC_FIRST && addr <= `PSS_ADDR_FUNC_LAST) begin
            kind = PSS_RK_FUNC;
        end
        return kind;
    endfunction

    pss_rkind_t addr_kind;

    assign addr_kind = pss_decode(reg_addr);

    // Register writes and reads
    always_comb begin
        for (int i = 0; i < `PSS_NUM_STEPS; i++) begin
            nxt_speed[i] = speed_ff[i];
            nxt_time[i] = time_ff[i];
        end
        for (int i = 0; i < `PSS_NUM_INPUTS; i++) begin
            nxt_func[i] = func_ff[i];
        end
        nxt_ramp_low = ramp_low_ff;
        nxt_ramp_high = ramp_high_ff;
        nxt_ctrl = ctrl_ff;
        nxt_rdata = `PSS_ZERO16;
        if (reg_wr) begin
            unique case (addr_kind)
                PSS_RK_SPEED: begin
                    nxt_speed[step_addr] = pss_clamp_speed(reg_wdata);
                end
                PSS_RK_TIME: begin
                    nxt_time[step_addr] = reg_wdata;
                end
                PSS_RK_RAMP_LOW: begin
                    nxt_ramp_low = reg_wdata;
                end
                PSS_RK_RAMP_HIGH: begin
                    nxt_ramp_high = reg_wdata;
                end
                PSS_RK_CONTROL: begin
                    nxt_ctrl = reg_wdata[`PSS_CTRL_W-1:0];
                end
                PSS_RK_FUNC: begin
                    nxt_func[func_addr] = reg_wdata[`PSS_FUNC_W-1:0];
                end
                PSS_RK_STATUS, PSS_RK_NONE: begin
                    // Status is read-only; a stray write must not move the step
                end
            endcase
        end
        if (reg_rd) begin
            unique case (addr_kind)
                PSS_RK_SPEED: begin
                    nxt_rdata = speed_ff[step_addr];
                end
                PSS_RK_TIME: begin
                    nxt_rdata = time_ff[step_addr];
                end
                PSS_RK_RAMP_LOW: begin
                    nxt_rdata = ramp_low_ff;
                end
                PSS_RK_RAMP_HIGH: begin
                    nxt_rdata = ramp_high_ff;
                end
                PSS_RK_STATUS: begin
                    nxt_rdata = {12'h000, step_ff};
                end
                PSS_RK_CONTROL: begin
                    nxt_rdata = {14'h0000, ctrl_ff};
                end
                PSS_RK_FUNC: begin
                    nxt_rdata = {11'h000, func_ff[func_addr]};
                end
                PSS_RK_NONE: begin
                    nxt_rdata = `PSS_ZERO16;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `PSS_NUM_STEPS; i++) begin
                speed_ff[i] <= `PSS_SPEED_RST;
                time_ff[i] <= `PSS_TIME_RST;
            end
            for (int i = 0; i < `PSS_NUM_INPUTS; i++) begin
                func_ff[i] <= `PSS_FUNC_RST;
            end
            ramp_low_ff <= `PSS_RAMP_RST;
            ramp_high_ff <= `PSS_RAMP_RST;
            ctrl_ff <= `PSS_CTRL_RST;
            rdata_ff <= `PSS_ZERO16;
        end else begin
            for (int i = 0; i < `PSS_NUM_STEPS; i++) begin
                speed_ff[i] <= nxt_speed[i];
                time_ff[i] <= nxt_time[i];
            end
            for (int i = 0; i < `PSS_NUM_INPUTS; i++) begin
                func_ff[i] <= nxt_func[i];
            end
            ramp_low_ff <= nxt_ramp_low;
            ramp_high_ff <= nxt_ramp_high;
            ctrl_ff <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
        end
    end

    // Selection bit b answers to the first selection code plus b, so its weight is 2**b;
    // a code that no input carries leaves its bit at zero
    genvar gb;
    generate
        for (gb = 0; gb < $bits(pss_pkg::pss_step_t); gb++) begin : g_sel
            assign sel_code[gb] = pss_has_func(func_ff, term_ff,
                pss_pkg::pss_func_t'(`PSS_FUNC_SEL_BIT1 + gb));
        end
    endgenerate

    // Step selection; several inputs on one code are ORed
    always_comb begin
        enable = ctrl_ff[`PSS_CTRL_ENABLE_BIT];
        pause_req = pss_has_func(func_ff, term_ff, `PSS_FUNC_PAUSE);
        nxt_step = step_ff;
        // Pause freezes the held step; on resume the step follows the current selection code
        if (enable && !pause_req) begin
            nxt_step = sel_code;
        end
    end

    // Ramp field, speed and time of the step in use, plus the unit, active and paused flags
    always_comb begin
        ramp_slot = step_ff[2:0];
        ramp_word = step_ff[3] ? ramp_high_ff : ramp_low_ff;
        nxt_ramp_out = ramp_word[ramp_slot*`PSS_RAMP_FIELD_W +: `PSS_RAMP_FIELD_W];
        nxt_speed_out = enable ? speed_ff[step_ff] : `PSS_ZERO16;
        nxt_time_out = time_ff[step_ff];
        nxt_minutes_out = ctrl_ff[`PSS_CTRL_MINUTES_BIT];
        nxt_active_out = enable;
        nxt_paused_out = enable && pause_req;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_ff <= `PSS_STEP_RST;
            speed_out_ff <= `PSS_ZERO16;
            time_out_ff <= `PSS_ZERO16;
            ramp_out_ff <= 2'h0;
            minutes_out_ff <= 1'b0;
            active_out_ff <= 1'b0;
            paused_out_ff <= 1'b0;
        end else begin
            step_ff <= nxt_step;
            speed_out_ff <= nxt_speed_out;
            time_out_ff <= nxt_time_out;
            ramp_out_ff <= nxt_ramp_out;
            minutes_out_ff <= nxt_minutes_out;
            active_out_ff <= nxt_active_out;
            paused_out_ff <= nxt_paused_out;
        end
    end

    assign reg_rdata = rdata_ff;
    assign speed_cmd = speed_out_ff;
    assign step_time = time_out_ff;
    assign time_in_minutes = minutes_out_ff;
    assign ramp_group = ramp_out_ff;
    assign active_step = step_ff;
    assign preset_active = active_out_ff;
    assign preset_paused = paused_out_ff;

endmodule

//--- verification/pss_term_drv.sv
// Terminal partner: a switch bank setting step code, pause and spare pins.
// Assumes step bits on pins 0-3, pause on pin 4, spare on pin 5.
`timescale 1ns/1ps
module pss_term_drv (
    input wire logic core_clk,
    input wire logic [3:0] step,
    input wire logic pause,
    input wire logic spare,
    output logic [5:0] term_in
);
    initial term_in = 6'h00;
    // Pins move only on an edge, like a latched switch bank
    always @(posedge core_clk) begin
        term_in <= {spare, pause, step};
    end
endmodule

//--- verification/pss_preset_speed_selector_chk.sv
// Port checker for the preset speed selector.
// Assumes it is bound to the design top and sees its ports only.
`timescale 1ns/1ps
module pss_preset_speed_selector_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [5:0] term_in,
    input wire logic [15:0] speed_cmd,
    input wire logic [15:0] step_time,
    input wire logic time_in_minutes,
    input wire logic [1:0] ramp_group,
    input wire logic [3:0] active_step,
    input wire logic preset_active,
    input wire logic preset_paused
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data not idle");
    chk_status_read: assert property (
        reg_rd && reg_addr == 8'h22 |=> reg_rdata == {12'h000, $past(active_step)})
        else $error("status read mismatch");
    chk_unmapped_read: assert property (
        reg_rd && reg_addr > 8'h29 |=> reg_rdata == 16'h0000) else $error("unmapped read");
    chk_speed_off: assert property (
        !preset_active [*2] |-> speed_cmd == 16'h0000) else $error("speed while disabled");
    chk_speed_range: assert property (
        $signed(speed_cmd) <= 16'sh03E8 && $signed(speed_cmd) >= -16'sh03E8)
        else $error("speed out of range");
    chk_pause_hold: assert property (
        preset_paused && $past(preset_paused) |-> $stable(active_step))
        else $error("step moved in pause");
    chk_step_enable: assert property (
        $changed(active_step) |-> $past(preset_active) || preset_active)
        else $error("step moved while disabled");
    chk_unit_write: assert property (
        $changed(time_in_minutes) |-> $past(reg_wr && reg_addr == 8'h23)
        || $past(reg_wr && reg_addr == 8'h23, 2)) else $error("unit changed unwritten");
endmodule

bind pss_preset_speed_selector pss_preset_speed_selector_chk u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .term_in(term_in),
    .speed_cmd(speed_cmd), .step_time(step_time), .time_in_minutes(time_in_minutes),
    .ramp_group(ramp_group), .active_step(active_step), .preset_active(preset_active),
    .preset_paused(preset_paused));

//--- verification/pss_preset_speed_selector_tb.sv
// Self-checking bench for the preset speed selector.
// Assumes design, package and checker are compiled before it.
`timescale 1ns/1ps
module pss_preset_speed_selector_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] step = 4'h0;
    logic pause = 1'b0;
    logic spare = 1'b0;
    logic [15:0] reg_rdata, speed_cmd, step_time, rd_val;
    logic [5:0] term_in;
    logic [1:0] ramp_group;
    logic [3:0] active_step;
    logic time_in_minutes, preset_active, preset_paused;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    // Rows: speed written per step, value expected after clamping
    logic [15:0] spd_wr [16] = '{16'h0000, 16'h0064, 16'h03E8, 16'h7FFF, 16'hFC18, 16'h8000,
        16'hFFFF, 16'h0001, 16'h01F4, 16'hFE0C, 16'h03E7, 16'hFC19, 16'h03E9, 16'hFC17,
        16'h0300, 16'hFD00};
    logic [15:0] spd_exp [16] = '{16'h0000, 16'h0064, 16'h03E8, 16'h03E8, 16'hFC18, 16'hFC18,
        16'hFFFF, 16'h0001, 16'h01F4, 16'hFE0C, 16'h03E7, 16'hFC19, 16'h03E8, 16'hFC18,
        16'h0300, 16'hFD00};

    always #5 core_clk = ~core_clk;

    pss_term_drv drv (.core_clk(core_clk), .step(step), .pause(pause), .spare(spare),
        .term_in(term_in));

    pss_preset_speed_selector dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .term_in(term_in), .speed_cmd(speed_cmd), .step_time(step_time),
        .time_in_minutes(time_in_minutes), .ramp_group(ramp_group),
        .active_step(active_step), .preset_active(preset_active),
        .preset_paused(preset_paused));

    function automatic logic [15:0] tim(input int k);
        return (k == 15) ? 16'hFFFF : 16'(k * 16'h0111);
    endfunction

    function automatic logic [15:0] rmp(input int k);
        logic [15:0] w;
        w = (k < 8) ? 16'hE4E4 : 16'h1B1B;
        return 16'(w[2 * (k % 8) +: 2]);
    endfunction

    task automatic results();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Ten cycles cover the partner latch, synchroniser, filter and output stage
    task automatic sel(input logic [3:0] s, input logic p);
        @(posedge core_clk);
        step <= s;
        pause <= p;
        repeat (10) @(posedge core_clk);
        #1;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            results();
        end
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int a = 8'h24; a < 8'h28; a++) wr(8'(a), 16'(a - 8'h14));
        wr(8'h28, 16'h0014);
        wr(8'h20, 16'hE4E4);
        wr(8'h21, 16'h1B1B);
        wr(8'h23, 16'h0001);
        for (int k = 0; k < 16; k++) begin
            wr(8'(2 * k), spd_wr[k]);
            wr(8'(2 * k + 1), tim(k));
        end
        for (int k = 0; k < 16; k++) begin
            sel(4'(k), 1'b0);
            chk(speed_cmd, spd_exp[k]);
            chk(step_time, tim(k));
            chk(ramp_group, rmp(k));
            chk(active_step, 16'(k));
            rd(8'h22, rd_val);
            chk(rd_val, 16'(k));
            rd(8'(2 * k), rd_val);
            chk(rd_val, spd_exp[k]);
        end
        $display("rows done");
        sel(4'h5, 1'b0);
        sel(4'h5, 1'b1);
        sel(4'h9, 1'b1);
        chk(active_step, 16'h0005);
        chk(preset_paused, 16'h0001);
        sel(4'h9, 1'b0);
        chk(active_step, 16'h0009);
        $display("pause done");
        @(posedge core_clk);
        spare <= 1'b1;
        sel(4'h3, 1'b0);
        chk(active_step, 16'h0003);
        wr(8'h29, 16'h0013);
        sel(4'h0, 1'b0);
        chk(active_step, 16'h0008);
        $display("terminals done");
        wr(8'h22, 16'h000F);
        rd(8'h22, rd_val);
        chk(rd_val, 16'h0008);
        rd(8'h2A, rd_val);
        chk(rd_val, 16'h0000);
        $display("refused done");
        wr(8'h23, 16'h0002);
        sel(4'h1, 1'b0);
        chk(speed_cmd, 16'h0000);
        chk(active_step, 16'h0008);
        chk(time_in_minutes, 16'h0001);
        chk(preset_active, 16'h0000);
        $display("disable done");
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8'h2B; a++) begin
            rd(8'(a), rd_val);
            chk(rd_val, 16'h0000);
        end
        chk(active_step, 16'h0000);
        $display("reset done");
        results();
    end
endmodule
